// File: hdl/dbx_pkg.sv
// Package for the debug breakpoint exception block: encodings, field layouts, reset values
package dbx_pkg;
  localparam int          DBX_NUM_BKPT      = 4;
  localparam int          DBX_ADDR_W        = 64;
  localparam int          DBX_PORT_W        = 16;
  localparam logic [7:0]  DBX_VECTOR        = 8'h01;
  // Access type encodings
  localparam logic [1:0]  DBX_RW_EXEC       = 2'h0;
  localparam logic [1:0]  DBX_RW_WRITE      = 2'h1;
  localparam logic [1:0]  DBX_RW_IO         = 2'h2;
  localparam logic [1:0]  DBX_RW_RDWR       = 2'h3;
  // Match length encodings
  localparam logic [1:0]  DBX_LEN_1         = 2'h0;
  localparam logic [1:0]  DBX_LEN_2         = 2'h1;
  localparam logic [1:0]  DBX_LEN_8         = 2'h2;
  localparam logic [1:0]  DBX_LEN_4         = 2'h3;
  // Status register layout
  localparam int          DBX_ST_BD_POS     = 13;
  localparam int          DBX_ST_BS_POS     = 14;
  localparam int          DBX_ST_BT_POS     = 15;
  localparam logic [15:0] DBX_STATUS_RESET  = 16'h0000;
  // Control register layout: enables at 2n (local) and 2n+1 (global), guard bit, fields from bit 16
  localparam int          DBX_CT_GD_POS     = 13;
  localparam int          DBX_CT_FIELD_POS  = 16;
  localparam logic [31:0] DBX_CONTROL_RESET = 32'h0000_0400;
  localparam logic [31:0] DBX_LOCAL_MASK    = 32'h0000_0055;
endpackage

// File: hdl/dbx_addr_match.sv
// One breakpoint slot comparator: range masking by match length
`timescale 1ns/1ps
module dbx_addr_match
  import dbx_pkg::*;
#(
  parameter int ADDR_W = DBX_ADDR_W
) (
  input  wire logic [ADDR_W-1:0] bkpt_addr_in,
  input  wire logic [1:0]        len_in,
  input  wire logic              long_mode_in,
  input  wire logic [ADDR_W-1:0] acc_addr_in,
  input  wire logic [3:0]        acc_size_in,
  output logic                   hit_out
);
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] acc_last;
  logic [ADDR_W-1:0] bk_lo;
  logic [ADDR_W-1:0] bk_hi;
  logic              len_ok;

  always_comb begin
    len_ok = 1'b1;
    unique case (len_in)
      DBX_LEN_1: mask = '0;
      DBX_LEN_2: mask = ADDR_W'(1);
      DBX_LEN_4: mask = ADDR_W'(3);
      DBX_LEN_8: begin
        mask   = ADDR_W'(7);
        len_ok = long_mode_in;
      end
    endcase
  end

  // Any accessed byte inside the aligned range counts as a hit
  assign bk_lo    = bkpt_addr_in & ~mask;
  assign bk_hi    = bk_lo | mask;
  assign acc_last = acc_addr_in + ADDR_W'(acc_size_in) - ADDR_W'(1);
  assign hit_out  = len_ok && (acc_size_in != 4'h0) && (acc_addr_in <= bk_hi) && (acc_last >= bk_lo);
endmodule

// File: hdl/dbx_io_match.sv
// I/O breakpoint comparator: zero-extended port compare, operation size check
`timescale 1ns/1ps
module dbx_io_match
  import dbx_pkg::*;
#(
  parameter int ADDR_W = DBX_ADDR_W,
  parameter int PORT_W = DBX_PORT_W
) (
  input  wire logic [ADDR_W-1:0] bkpt_addr_in,
  input  wire logic [1:0]        len_in,
  input  wire logic [PORT_W-1:0] port_in,
  input  wire logic [3:0]        io_size_in,
  output logic                   hit_out
);
  logic [ADDR_W-1:0] port_ext;
  logic [3:0]        want;

  assign port_ext = {{(ADDR_W-PORT_W){1'b0}}, port_in};

  always_comb begin
    unique case (len_in)
      DBX_LEN_1: want = 4'h1;
      DBX_LEN_2: want = 4'h2;
      DBX_LEN_4: want = 4'h4;
      DBX_LEN_8: want = 4'h0;
    endcase
  end

  assign hit_out = (want != 4'h0) && (io_size_in == want) && (port_ext == bkpt_addr_in);
endmodule

// File: hdl/dbx_debug_unit.sv
// Debug exception unit: breakpoint detection, priority, status flags and flag side effects
`timescale 1ns/1ps
module dbx_debug_unit
  import dbx_pkg::*;
#(
  parameter int NUM_BKPT = DBX_NUM_BKPT,
  parameter int ADDR_W   = DBX_ADDR_W,
  parameter int PORT_W   = DBX_PORT_W
) (
  input  wire logic                   clock_in,
  input  wire logic                   srst_in,
  // Debug register writes from the instruction stream
  input  wire logic                   addr_wr_in,
  input  wire logic [1:0]             addr_sel_in,
  input  wire logic [ADDR_W-1:0]      addr_wdata_in,
  input  wire logic                   ctl_wr_in,
  input  wire logic [31:0]            ctl_wdata_in,
  input  wire logic                   status_wr_in,
  input  wire logic [15:0]            status_wdata_in,
  input  wire logic                   debug_ext_enable_in,
  input  wire logic                   long_mode_in,
  // Instruction boundary: next instruction about to execute
  input  wire logic                   fetch_valid_in,
  input  wire logic [ADDR_W-1:0]      fetch_addr_in,
  input  wire logic                   dreg_access_in,
  // Instruction completion
  input  wire logic                   retire_in,
  input  wire logic [ADDR_W-1:0]      retire_addr_in,
  input  wire logic [ADDR_W-1:0]      next_addr_in,
  input  wire logic                   mem_valid_in,
  input  wire logic                   mem_write_in,
  input  wire logic [ADDR_W-1:0]      mem_addr_in,
  input  wire logic [3:0]             mem_size_in,
  input  wire logic                   io_valid_in,
  input  wire logic [PORT_W-1:0]      io_port_in,
  input  wire logic [3:0]             io_size_in,
  input  wire logic                   rep_incomplete_in,
  input  wire logic                   soft_int_in,
  input  wire logic                   task_switch_in,
  input  wire logic                   task_trap_bit_in,
  // Flags register writes from software
  input  wire logic                   flags_wr_in,
  input  wire logic                   trap_flag_wdata_in,
  input  wire logic                   resume_flag_wdata_in,
  input  wire logic                   ext_int_pending_in,
  // Exception delivery
  output logic                        debug_exception_out,
  output logic [7:0]                  vector_out,
  output logic [ADDR_W-1:0]           push_addr_out,
  output logic                        push_trap_flag_out,
  output logic                        int_after_entry_out,
  output logic                        trap_flag_out,
  output logic                        resume_flag_out,
  output logic [15:0]                 debug_status_reg_out,
  output logic [31:0]                 debug_control_reg_out,
  output logic [NUM_BKPT*ADDR_W-1:0]  bkpt_addr_reg_out
);
  logic [ADDR_W-1:0] bkpt_addr_reg_q [NUM_BKPT];
  logic [31:0]       ctl_q;
  logic [15:0]       status_q;
  logic              trap_flag_q;
  logic              resume_flag_q;
  logic              step_arm_q;
  logic [NUM_BKPT-1:0] inst_hit;
  logic [NUM_BKPT-1:0] data_hit;
  logic [NUM_BKPT-1:0] io_hit;
  logic [NUM_BKPT-1:0] data_raw;
  logic [NUM_BKPT-1:0] io_raw;
  logic              guard_hit;
  logic              before_exc;
  logic              after_hit;
  logic              step_hit;
  logic              task_hit;
  logic              after_exc;
  logic              exc;
  logic [31:0]       ctl_d;
  logic [15:0]       status_d;

  // Per-slot decode of enables, type and length
  for (genvar n = 0; n < NUM_BKPT; n++) begin : g_slot
    logic       en;
    logic [1:0] rw;
    logic [1:0] len;
    assign en  = ctl_q[2*n] | ctl_q[2*n+1];
    assign rw  = ctl_q[DBX_CT_FIELD_POS+4*n +: 2];
    assign len = ctl_q[DBX_CT_FIELD_POS+4*n+2 +: 2];
    // Software keeps length at one byte here; compare exact address only
    assign inst_hit[n] = en && rw == DBX_RW_EXEC && fetch_valid_in
                      && fetch_addr_in == bkpt_addr_reg_q[n] && !resume_flag_q;
    dbx_addr_match #(.ADDR_W(ADDR_W)) u_data (
      .bkpt_addr_in (bkpt_addr_reg_q[n]),
      .len_in       (len),
      .long_mode_in (long_mode_in),
      .acc_addr_in  (mem_addr_in),
      .acc_size_in  (mem_size_in),
      .hit_out      (data_raw[n])
    );
    assign data_hit[n] = en && mem_valid_in && data_raw[n]
                      && (rw == DBX_RW_RDWR || (rw == DBX_RW_WRITE && mem_write_in));
    dbx_io_match #(.ADDR_W(ADDR_W), .PORT_W(PORT_W)) u_io (
      .bkpt_addr_in (bkpt_addr_reg_q[n]),
      .len_in       (len),
      .port_in      (io_port_in),
      .io_size_in   (io_size_in),
      .hit_out      (io_raw[n])
    );
    assign io_hit[n] = en && rw == DBX_RW_IO && debug_ext_enable_in && io_valid_in && io_raw[n];
    assign bkpt_addr_reg_out[n*ADDR_W +: ADDR_W] = bkpt_addr_reg_q[n];
    a_len8_mode: assert property (@(posedge clock_in) disable iff (srst_in)
      len == DBX_LEN_8 && !long_mode_in |-> !data_raw[n])
      else $error("Eight-byte range matched outside long mode");
    a_io_size: assert property (@(posedge clock_in) disable iff (srst_in)
      io_raw[n] |-> io_size_in == (len == DBX_LEN_2 ? 4'h2 : (len == DBX_LEN_4 ? 4'h4 : 4'h1)))
      else $error("I/O hit on wrong operation size");
    a_io_zext: assert property (@(posedge clock_in) disable iff (srst_in)
      io_raw[n] |-> bkpt_addr_reg_q[n] == ADDR_W'(io_port_in))
      else $error("I/O port compare not zero-extended");
  end

  assign guard_hit  = fetch_valid_in && dreg_access_in && ctl_q[DBX_CT_GD_POS];
  // After-completion conditions; a repeated port string reports each iteration
  assign after_hit  = retire_in && ((|data_hit) || (|io_hit));
  // The setter and its follower are skipped through the arm stage
  assign step_hit   = retire_in && trap_flag_q && step_arm_q && !soft_int_in;
  // The task's trap bit is only read here; clearing it is left to software
  assign task_hit   = retire_in && task_switch_in && task_trap_bit_in;
  assign after_exc  = after_hit || step_hit || task_hit;
  // Pending completion traps win over a new fetch-side hit
  assign before_exc = !after_exc && ((|inst_hit) || guard_hit);
  assign exc        = after_exc || before_exc;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < NUM_BKPT; i++) begin
        bkpt_addr_reg_q[i] <= '0;
      end
    end else if (addr_wr_in && !guard_hit) begin
      bkpt_addr_reg_q[addr_sel_in] <= addr_wdata_in;
    end
  end

  // Guard clear is applied last so a task switch in the same cycle still drops local enables
  always_comb begin
    ctl_d = ctl_q;
    if (ctl_wr_in && !guard_hit) begin
      ctl_d = ctl_wdata_in;
    end else if (retire_in && task_switch_in) begin
      ctl_d = ctl_q & ~DBX_LOCAL_MASK;
    end
    if (before_exc && guard_hit) begin
      ctl_d[DBX_CT_GD_POS] = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctl_q <= DBX_CONTROL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_comb begin
    status_d = status_wr_in ? status_wdata_in : status_q;
    if (after_exc) begin
      status_d[NUM_BKPT-1:0] = status_d[NUM_BKPT-1:0] | data_hit | io_hit;
      status_d[DBX_ST_BS_POS] = status_d[DBX_ST_BS_POS] | step_hit;
      status_d[DBX_ST_BT_POS] = status_d[DBX_ST_BT_POS] | task_hit;
    end else if (before_exc) begin
      status_d[NUM_BKPT-1:0] = status_d[NUM_BKPT-1:0] | inst_hit;
      status_d[DBX_ST_BD_POS] = status_d[DBX_ST_BD_POS] | guard_hit;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      status_q <= DBX_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Trap flag, stepping arm and resume flag
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trap_flag_q <= 1'b0;
      step_arm_q  <= 1'b0;
    end else if (flags_wr_in) begin
      trap_flag_q <= trap_flag_wdata_in;
      step_arm_q  <= 1'b0;
    end else if (exc || (retire_in && soft_int_in)) begin
      trap_flag_q <= 1'b0;
      step_arm_q  <= 1'b0;
    end else if (retire_in && trap_flag_q) begin
      step_arm_q  <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      resume_flag_q <= 1'b0;
    end else if (flags_wr_in) begin
      resume_flag_q <= resume_flag_wdata_in;
    end else if (retire_in) begin
      resume_flag_q <= 1'b0;
    end
  end

  // Exception report registered one cycle after the cause
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      debug_exception_out <= 1'b0;
      vector_out          <= 8'h00;
      push_addr_out       <= '0;
      push_trap_flag_out  <= 1'b0;
      int_after_entry_out <= 1'b0;
    end else begin
      debug_exception_out <= exc;
      vector_out          <= exc ? DBX_VECTOR : 8'h00;
      push_trap_flag_out  <= exc && trap_flag_q;
      int_after_entry_out <= step_hit && ext_int_pending_in;
      if (before_exc) begin
        push_addr_out <= fetch_addr_in;
      end else if (after_exc) begin
        push_addr_out <= rep_incomplete_in ? retire_addr_in : next_addr_in;
      end
    end
  end

  assign trap_flag_out         = trap_flag_q;
  assign resume_flag_out       = resume_flag_q;
  assign debug_status_reg_out  = status_q;
  assign debug_control_reg_out = ctl_q;

  a_vector_one: assert property (@(posedge clock_in) disable iff (srst_in)
    exc |=> debug_exception_out && vector_out == 8'h01) else $error("Wrong debug vector");
  a_after_first: assert property (@(posedge clock_in) disable iff (srst_in)
    after_exc |-> !before_exc) else $error("Fetch hit beat a completion trap");
  a_resume_mask: assert property (@(posedge clock_in) disable iff (srst_in)
    resume_flag_q |-> inst_hit == '0) else $error("Instruction hit while resume set");
  a_resume_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    retire_in && !flags_wr_in |=> !resume_flag_q) else $error("Resume flag not cleared");
  a_guard_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    before_exc && guard_hit |=> !ctl_q[DBX_CT_GD_POS] && status_q[DBX_ST_BD_POS])
    else $error("Guard not handled");
  a_step_flags: assert property (@(posedge clock_in) disable iff (srst_in)
    step_hit && !flags_wr_in |=> !trap_flag_q && status_q[DBX_ST_BS_POS] && push_trap_flag_out)
    else $error("Step entry flags wrong");
  a_soft_int_tf: assert property (@(posedge clock_in) disable iff (srst_in)
    retire_in && soft_int_in && !flags_wr_in |=> !trap_flag_q) else $error("Soft interrupt kept trap flag");
  a_inst_push: assert property (@(posedge clock_in) disable iff (srst_in)
    before_exc |=> push_addr_out == $past(fetch_addr_in)) else $error("Wrong instruction push address");
  a_task_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    task_hit |=> status_q[DBX_ST_BT_POS] && debug_exception_out) else $error("Task trap not flagged");
  a_flags_sticky: assert property (@(posedge clock_in) disable iff (srst_in)
    !status_wr_in |=> (status_q & $past(status_q)) == $past(status_q)) else $error("Hit flag lost");

  // Stepping: a flags write that sets the trap flag, then ordinary retirements
  sequence s_trap_set;
    flags_wr_in && trap_flag_wdata_in;
  endsequence
  sequence s_plain_retire;
    retire_in && !flags_wr_in && !soft_int_in && !after_hit && !task_hit && !(|inst_hit) && !guard_hit;
  endsequence
  a_step_skip: assert property (@(posedge clock_in) disable iff (srst_in)
    s_trap_set ##1 s_plain_retire |-> !step_hit)
    else $error("Follower of the trap setter was stepped");
  a_step_next: assert property (@(posedge clock_in) disable iff (srst_in)
    s_trap_set ##1 s_plain_retire ##1 s_plain_retire |-> step_hit)
    else $error("Step trap missing");
  a_step_int: assert property (@(posedge clock_in) disable iff (srst_in)
    step_hit && ext_int_pending_in && !flags_wr_in |=> int_after_entry_out && !trap_flag_q)
    else $error("Pending interrupt not ordered after step entry");
  a_after_push: assert property (@(posedge clock_in) disable iff (srst_in)
    after_exc && !rep_incomplete_in |=> push_addr_out == $past(next_addr_in))
    else $error("Wrong completion push address");
  a_rep_push: assert property (@(posedge clock_in) disable iff (srst_in)
    after_exc && rep_incomplete_in |=> push_addr_out == $past(retire_addr_in))
    else $error("Wrong push address for unfinished repeat");
  a_data_first: assert property (@(posedge clock_in) disable iff (srst_in)
    after_hit && (|inst_hit) && !status_wr_in && status_q[NUM_BKPT-1:0] == '0
      |=> status_q[NUM_BKPT-1:0] == $past(data_hit | io_hit))
    else $error("Fetch hit reported with a completion trap");
  a_local_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    retire_in && task_switch_in && !ctl_wr_in |=> (ctl_q & DBX_LOCAL_MASK) == 32'h0
      && ((ctl_q ^ $past(ctl_q)) & ~DBX_LOCAL_MASK & ~(32'h1 << DBX_CT_GD_POS)) == 32'h0)
    else $error("Task switch touched more than local enables");
  a_guard_block: assert property (@(posedge clock_in) disable iff (srst_in)
    guard_hit |=> $stable(bkpt_addr_reg_out))
    else $error("Guarded move altered a breakpoint address");
  a_trap_image: assert property (@(posedge clock_in) disable iff (srst_in)
    exc && !trap_flag_q |=> !push_trap_flag_out)
    else $error("Pushed trap flag set without stepping");
endmodule

// File: tb/test_dbx_debug_unit.sv
// Self-checking bench for the debug exception unit: breakpoint, guard, task and step scenarios
`timescale 1ns/1ps
module test_dbx_debug_unit;
  import dbx_pkg::*;
  // One packed word drives every pulse input so each op assigns it exactly once per step
  localparam logic [13:0] WA = 14'h0001, WC = 14'h0002, WS = 14'h0004, FV = 14'h0008, DA = 14'h0010;
  localparam logic [13:0] RT = 14'h0020, MV = 14'h0040, MW = 14'h0080, IO = 14'h0100, RI = 14'h0200;
  localparam logic [13:0] SI = 14'h0400, TS = 14'h0800, TB = 14'h1000, FW = 14'h2000;
  logic         clock_in, srst_in, debug_ext_enable_in, long_mode_in, ext_int_pending_in;
  logic         trap_flag_wdata_in, resume_flag_wdata_in;
  logic [13:0]  pls;
  logic [1:0]   addr_sel_in;
  logic [63:0]  addr_wdata_in, fetch_addr_in, retire_addr_in, next_addr_in, mem_addr_in;
  logic [31:0]  ctl_wdata_in;
  logic [15:0]  status_wdata_in, io_port_in;
  logic [3:0]   mem_size_in, io_size_in;
  logic         debug_exception_out, push_trap_flag_out, int_after_entry_out, trap_flag_out, resume_flag_out;
  logic [7:0]   vector_out;
  logic [63:0]  push_addr_out;
  logic [15:0]  debug_status_reg_out;
  logic [31:0]  debug_control_reg_out;
  logic [255:0] bkpt_addr_reg_out;
  int           num_errors = 0;
  int           num_checks = 0;

  dbx_debug_unit u_dbx_debug_unit (
    .clock_in, .srst_in, .addr_wr_in(pls[0]), .addr_sel_in, .addr_wdata_in, .ctl_wr_in(pls[1]), .ctl_wdata_in,
    .status_wr_in(pls[2]), .status_wdata_in, .debug_ext_enable_in, .long_mode_in, .fetch_valid_in(pls[3]),
    .fetch_addr_in, .dreg_access_in(pls[4]), .retire_in(pls[5]), .retire_addr_in, .next_addr_in,
    .mem_valid_in(pls[6]), .mem_write_in(pls[7]), .mem_addr_in, .mem_size_in, .io_valid_in(pls[8]), .io_port_in,
    .io_size_in, .rep_incomplete_in(pls[9]), .soft_int_in(pls[10]), .task_switch_in(pls[11]),
    .task_trap_bit_in(pls[12]), .flags_wr_in(pls[13]), .trap_flag_wdata_in, .resume_flag_wdata_in,
    .ext_int_pending_in, .debug_exception_out, .vector_out, .push_addr_out, .push_trap_flag_out,
    .int_after_entry_out, .trap_flag_out, .resume_flag_out, .debug_status_reg_out, .debug_control_reg_out,
    .bkpt_addr_reg_out);

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Drive one cycle of pulses; outputs registered at that edge are visible on return
  task automatic op(input logic [13:0] p);
    pls = p;
    @(posedge clock_in);
    #1;
  endtask

  task automatic exc(input logic e, input logic [63:0] pa);
    chk(64'(debug_exception_out), 64'(e));
    if (e) begin
      chk(64'(vector_out), 64'(DBX_VECTOR));
      chk(push_addr_out, pa);
    end
  endtask

  task automatic waddr(input logic [1:0] s, input logic [63:0] a);
    addr_sel_in = s;
    addr_wdata_in = a;
    op(WA);
  endtask

  task automatic wctl(input logic [31:0] v);
    ctl_wdata_in = v;
    op(WC);
  endtask

  task automatic wst(input logic [15:0] v);
    status_wdata_in = v;
    op(WS);
  endtask

  task automatic wflags(input logic t, input logic r);
    trap_flag_wdata_in = t;
    resume_flag_wdata_in = r;
    op(FW);
  endtask

  task automatic retire_at(input logic [63:0] a, input logic [63:0] n, input logic [13:0] p);
    retire_addr_in = a;
    next_addr_in = n;
    op(RT | p);
  endtask

  // Whole run is well under a hundred cycles; this only catches a hang
  initial begin
    repeat (2000) @(posedge clock_in);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired %h %h", $time, 64'h1, 64'h0);
    stop_test();
  end

  initial begin
    {debug_ext_enable_in, long_mode_in, ext_int_pending_in, trap_flag_wdata_in, resume_flag_wdata_in} = '0;
    {addr_sel_in, addr_wdata_in, fetch_addr_in, retire_addr_in, next_addr_in, mem_addr_in} = '0;
    {ctl_wdata_in, status_wdata_in, io_port_in, mem_size_in, io_size_in} = '0;
    pls = '0;
    srst_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    srst_in = 1'b0;
    chk(64'(debug_control_reg_out), 64'(DBX_CONTROL_RESET));
    chk(64'(debug_status_reg_out), 64'h0);
    // Write-only data breakpoint, four bytes at f004
    waddr(2'h0, 64'hf004);
    wctl(32'h000d_0402);
    mem_addr_in = 64'hf005;
    mem_size_in = 4'h4;
    retire_at(64'h2004, 64'h2008, MV | MW); exc(1'b1, 64'h2008);
    chk(64'(debug_status_reg_out), 64'h1);
    retire_at(64'h2004, 64'h2008, MV); exc(1'b0, 64'h0);
    mem_addr_in = 64'hf000;
    retire_at(64'h2004, 64'h2008, MV | MW); exc(1'b0, 64'h0);
    mem_addr_in = 64'hf007;
    mem_size_in = 4'h1;
    retire_at(64'h2004, 64'h2008, MV | MW | RI); exc(1'b1, 64'h2004);
    // Eight-byte range covers f000 to f007, but only in long mode
    wctl(32'h0009_0402);
    mem_addr_in = 64'hf001;
    retire_at(64'h2004, 64'h2008, MV | MW); exc(1'b0, 64'h0);
    long_mode_in = 1'b1;
    retire_at(64'h2004, 64'h2008, MV | MW); exc(1'b1, 64'h2008);
    long_mode_in = 1'b0;
    // Instruction breakpoint in slot one, local enable
    waddr(2'h1, 64'h1000);
    wctl(32'h000d_0406);
    fetch_addr_in = 64'h1000;
    op(FV); exc(1'b1, 64'h1000);
    chk(64'(debug_status_reg_out), 64'h3);
    wst(16'h0000);
    chk(64'(debug_status_reg_out), 64'h0);
    fetch_addr_in = 64'h1001;
    op(FV); exc(1'b0, 64'h0);
    wflags(1'b0, 1'b1);
    fetch_addr_in = 64'h1000;
    op(FV); exc(1'b0, 64'h0);
    retire_at(64'h1000, 64'h1004, 14'h0); chk(64'(resume_flag_out), 64'h0);
    op(FV); exc(1'b1, 64'h1000);
    // Data hit of the retiring instruction wins; the fetch hit comes on the retry
    wst(16'h0000);
    mem_addr_in = 64'hf004;
    retire_at(64'h0ffc, 64'h1000, FV | MV | MW); exc(1'b1, 64'h1000);
    chk(64'(debug_status_reg_out), 64'h1);
    op(FV); exc(1'b1, 64'h1000);
    chk(64'(debug_status_reg_out), 64'h3);
    wst(16'h0000);
    // Byte I/O breakpoint on port 60 in slot two
    debug_ext_enable_in = 1'b1;
    waddr(2'h2, 64'h60);
    wctl(32'h020d_0426);
    io_port_in = 16'h0060;
    io_size_in = 4'h1;
    retire_at(64'h3000, 64'h3002, IO); exc(1'b1, 64'h3002);
    chk(64'(debug_status_reg_out), 64'h4);
    io_size_in = 4'h2;
    retire_at(64'h3000, 64'h3002, IO); exc(1'b0, 64'h0);
    io_size_in = 4'h1;
    retire_at(64'h3000, 64'h3002, IO | RI); exc(1'b1, 64'h3000);
    debug_ext_enable_in = 1'b0;
    retire_at(64'h3000, 64'h3002, IO); exc(1'b0, 64'h0);
    wst(16'h0000);
    // Switch into a task with its trap bit set
    retire_at(64'h3100, 64'h8000, TS | TB); chk(64'(debug_exception_out), 64'h1);
    chk(64'(debug_status_reg_out), 64'h8000);
    chk(64'(debug_control_reg_out), 64'h020d_0422);
    wst(16'h0000);
    // Guarded debug register move; the write riding along must be dropped
    wctl(32'h0000_2400);
    addr_sel_in = 2'h3;
    addr_wdata_in = 64'hbeef;
    fetch_addr_in = 64'h4000;
    op(FV | DA | WA); exc(1'b1, 64'h4000);
    chk(64'(debug_status_reg_out), 64'h2000);
    chk(64'(debug_control_reg_out), 64'h0000_0400);
    chk(bkpt_addr_reg_out[255:192], 64'h0);
    wst(16'h0000);
    // Single step with an interrupt waiting
    ext_int_pending_in = 1'b1;
    wflags(1'b1, 1'b0); chk(64'(trap_flag_out), 64'h1);
    retire_at(64'h5000, 64'h5004, 14'h0); exc(1'b0, 64'h0);
    retire_at(64'h5004, 64'h5008, 14'h0); exc(1'b1, 64'h5008);
    chk(64'(trap_flag_out), 64'h0);
    chk(64'(push_trap_flag_out), 64'h1);
    chk(64'(debug_status_reg_out), 64'h4000);
    chk(64'(int_after_entry_out), 64'h1);
    ext_int_pending_in = 1'b0;
    // Software interrupt drops the trap flag, so nothing is stepped after it
    wflags(1'b1, 1'b0);
    retire_at(64'h6000, 64'h6002, SI); chk(64'(trap_flag_out), 64'h0);
    retire_at(64'h6002, 64'h6004, 14'h0); exc(1'b0, 64'h0);
    op(14'h0);
    stop_test();
  end
endmodule
